// ==== core/llic_pkg.sv ====
/*
 Constants shared by the lock indicator and link controller and its pulse timer.
 Assumes a 25 MHz core clock; all times except the one-second deny delay (DENY_CYC in llic_top) are turned into cycle counts here.
*/
// Function
// - power-up: red major, green minor, silent
// - relock: one red flash, one beep
// - rex plus card held 8 s starts link
// - green flash, up to three requests per channel
// - twenty second error test, flash per result
// - success: channel count green flashes and beeps
// - failure: two red flashes, one long beep
// - card read beeps once, unread silent
// - reader lost: one red flash, no sound
// - denied: two red flashes, one beep, delayed
// - granted: unlock, green flash, then relock
package llic_pkg;
	localparam int unsigned CLK_HZ = 25000000;
	localparam int unsigned FLASH_MS = 200;
	localparam int unsigned GAP_MS = 200;
	localparam int unsigned LONG_MS = 1000;
	localparam int unsigned HOLD_S = 8;
	localparam int unsigned PER_S = 20;
	localparam int unsigned RELOCK_S = 3;
	localparam int unsigned REPLY_MS = 100;
	localparam int unsigned FLASH_CYC = CLK_HZ / 1000 * FLASH_MS;
	localparam int unsigned GAP_CYC = CLK_HZ / 1000 * GAP_MS;
	localparam int unsigned LONG_CYC = CLK_HZ / 1000 * LONG_MS;
	localparam int unsigned HOLD_CYC = CLK_HZ * HOLD_S;
	localparam int unsigned PER_CYC = CLK_HZ * PER_S;
	localparam int unsigned RELOCK_CYC = CLK_HZ * RELOCK_S;
	localparam int unsigned REPLY_CYC = CLK_HZ / 1000 * REPLY_MS;
	localparam logic [3:0] CHAN_FIRST = 4'h1;
	localparam logic [3:0] CHAN_LAST = 4'hf;
	localparam logic [1:0] REQ_TRIES = 2'h3;
	localparam logic [3:0] DENY_FLASHES = 4'h2;
	localparam logic [3:0] FAIL_FLASHES = 4'h2;
	localparam logic [3:0] ONE = 4'h1;
	typedef enum logic [1:0] {LLIC_RED, LLIC_GREEN, LLIC_NONE} llic_colour_t;
	typedef enum {
		LLIC_IDLE, LLIC_VER_MAJ, LLIC_VER_MIN, LLIC_ARM, LLIC_LINK_GO, LLIC_REQ,
		LLIC_WAIT, LLIC_PER, LLIC_PER_END, LLIC_OK, LLIC_FAIL, LLIC_DENY_WAIT,
		LLIC_DENY, LLIC_UNLOCK, LLIC_OPEN, LLIC_RELOCK, LLIC_DONE
	} llic_state_t;
endpackage

// ==== core/llic_pulser.sv ====
/*
 Pulse train generator: emits a number of flashes with optional beeps.
 Assumes start is a one-cycle request while busy is low.
*/
`timescale 1ns/1ps
module llic_pulser #(
	parameter int unsigned ON_CYC = llic_pkg::FLASH_CYC,
	parameter int unsigned OFF_CYC = llic_pkg::GAP_CYC,
	parameter int unsigned LONG_CYC = llic_pkg::LONG_CYC
) (
	// clocking
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	// request
	input wire logic start_in,
	input wire logic [3:0] count_in,
	input wire logic red_in,
	input wire logic green_in,
	input wire logic [3:0] beeps_in,
	input wire logic long_in,
	// outputs
	output logic busy_out,
	output logic red_out,
	output logic green_out,
	output logic beep_out
);
	logic [3:0] left_r;
	logic [3:0] beeps_r;
	logic red_r;
	logic green_r;
	logic long_r;
	logic on_r;
	logic [31:0] cnt_r;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			left_r <= 4'h0;
			beeps_r <= 4'h0;
			red_r <= 1'b0;
			green_r <= 1'b0;
			long_r <= 1'b0;
			on_r <= 1'b0;
			cnt_r <= 32'h0;
			busy_out <= 1'b0;
			red_out <= 1'b0;
			green_out <= 1'b0;
			beep_out <= 1'b0;
		end else if (ce_in) begin
			if (!busy_out) begin
				if (start_in && (count_in != 4'h0 || beeps_in != 4'h0)) begin
					left_r <= (count_in > beeps_in) ? count_in : beeps_in;
					beeps_r <= beeps_in;
					red_r <= red_in;
					green_r <= green_in;
					long_r <= long_in;
					busy_out <= 1'b1;
					on_r <= 1'b0;
					cnt_r <= 32'h0;
				end
			end else if (cnt_r != 32'h0) begin
				cnt_r <= cnt_r - 32'h1;
			end else if (!on_r) begin
				if (left_r == 4'h0) begin
					busy_out <= 1'b0;
				end else begin
					on_r <= 1'b1;
					red_out <= red_r;
					green_out <= green_r;
					beep_out <= beeps_r != 4'h0;
					cnt_r <= (long_r && beeps_r != 4'h0) ? LONG_CYC - 1 : ON_CYC - 1;
				end
			end else begin
				on_r <= 1'b0;
				red_out <= 1'b0;
				green_out <= 1'b0;
				beep_out <= 1'b0;
				left_r <= left_r - 4'h1;
				if (beeps_r != 4'h0) begin
					beeps_r <= beeps_r - 4'h1;
				end
				cnt_r <= OFF_CYC - 1;
			end
		end
	end
endmodule

// ==== core/llic_top.sv ====
/*
 Lock link and indicator controller: link sequence over the RF modem
 and LED/sounder patterns for version, card, access and relock events.
 Assumes an RF modem and reader front end on the same clock, except the
 lever and card-present pins which are synchronised here.
*/
`timescale 1ns/1ps
module llic_top #(
	parameter int unsigned HOLD_CYC = llic_pkg::HOLD_CYC,
	parameter int unsigned PER_CYC = llic_pkg::PER_CYC,
	parameter int unsigned RELOCK_CYC = llic_pkg::RELOCK_CYC,
	parameter int unsigned REPLY_CYC = llic_pkg::REPLY_CYC,
	parameter int unsigned DENY_CYC = llic_pkg::CLK_HZ,
	parameter int unsigned ON_CYC = llic_pkg::FLASH_CYC,
	parameter int unsigned OFF_CYC = llic_pkg::GAP_CYC,
	parameter int unsigned LONG_CYC = llic_pkg::LONG_CYC,
	parameter logic [3:0] VER_MAJOR = 4'h1,
	parameter logic [3:0] VER_MINOR = 4'h0
) (
	// clocking
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	// pins from the door
	input wire logic rex_in,
	input wire logic card_present_in,
	// reader front end, same clock
	input wire logic card_read_in,
	input wire logic reader_lost_in,
	input wire logic access_grant_in,
	input wire logic access_deny_in,
	// rf modem, same clock
	input wire logic rf_reply_in,
	input wire logic rf_good_in,
	input wire logic rf_bad_in,
	input wire logic rf_quality_ok_in,
	// rf modem controls
	output logic rf_req_out,
	output logic [3:0] rf_chan_out,
	output logic linked_out,
	// actuators and indicators
	output logic motor_unlock_out,
	output logic motor_lock_out,
	output logic led_red_out,
	output logic led_green_out,
	output logic sounder_out
);
	logic rst_s1_r;
	logic rst_r;
	logic rex_s1_r;
	logic rex_r;
	logic card_s1_r;
	logic card_r;
	logic card_d_r;
	llic_pkg::llic_state_t state_r;
	logic [31:0] tmr_r;
	logic [1:0] tries_r;
	logic [3:0] chan_r;
	logic p_start_nxt;
	logic [3:0] p_cnt_nxt;
	logic p_red_nxt;
	logic p_green_nxt;
	logic [3:0] p_beep_nxt;
	logic p_long_nxt;
	logic p_busy;
	logic p_red;
	logic p_green;
	logic p_beep;
	logic rx_red_r;
	logic rx_green_r;
	logic card_edge;
	logic in_link;

	// reset release is synchronised so all state leaves reset together
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_s1_r <= 1'b0;
			rst_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_r <= rst_s1_r;
		end
	end

	// lever and card pins are asynchronous to the core clock
	always_ff @(posedge core_clk_in or negedge rst_r) begin
		if (!rst_r) begin
			rex_s1_r <= 1'b0;
			rex_r <= 1'b0;
			card_s1_r <= 1'b0;
			card_r <= 1'b0;
			card_d_r <= 1'b0;
		end else if (ce_in) begin
			rex_s1_r <= rex_in;
			rex_r <= rex_s1_r;
			card_s1_r <= card_present_in;
			card_r <= card_s1_r;
			card_d_r <= card_r;
		end
	end

	assign card_edge = card_r && !card_d_r;
	assign in_link = state_r == llic_pkg::LLIC_PER;

	// pulse requests per state; the train runs to completion before the next
	always_comb begin
		p_start_nxt = 1'b0;
		p_cnt_nxt = 4'h0;
		p_red_nxt = 1'b0;
		p_green_nxt = 1'b0;
		p_beep_nxt = 4'h0;
		p_long_nxt = 1'b0;
		if (!p_busy) begin
			case (state_r)
				llic_pkg::LLIC_VER_MAJ: begin
					p_start_nxt = 1'b1;
					p_cnt_nxt = VER_MAJOR;
					p_red_nxt = 1'b1;
				end
				llic_pkg::LLIC_VER_MIN: begin
					p_start_nxt = 1'b1;
					p_cnt_nxt = VER_MINOR;
					p_green_nxt = 1'b1;
				end
				llic_pkg::LLIC_LINK_GO: begin
					p_start_nxt = 1'b1;
					p_cnt_nxt = llic_pkg::ONE;
					p_green_nxt = 1'b1;
				end
				llic_pkg::LLIC_REQ: begin
					p_start_nxt = 1'b1;
					p_cnt_nxt = llic_pkg::ONE;
					p_red_nxt = 1'b1;
				end
				llic_pkg::LLIC_OK: begin
					p_start_nxt = 1'b1;
					p_cnt_nxt = chan_r;
					p_green_nxt = 1'b1;
					p_beep_nxt = chan_r;
				end
				llic_pkg::LLIC_FAIL: begin
					p_start_nxt = 1'b1;
					p_cnt_nxt = llic_pkg::FAIL_FLASHES;
					p_red_nxt = 1'b1;
					p_beep_nxt = llic_pkg::ONE;
					p_long_nxt = 1'b1;
				end
				llic_pkg::LLIC_DENY: begin
					p_start_nxt = 1'b1;
					p_cnt_nxt = llic_pkg::DENY_FLASHES;
					p_red_nxt = 1'b1;
					p_beep_nxt = llic_pkg::ONE;
				end
				llic_pkg::LLIC_UNLOCK: begin
					p_start_nxt = 1'b1;
					p_cnt_nxt = llic_pkg::ONE;
					p_green_nxt = 1'b1;
				end
				llic_pkg::LLIC_RELOCK: begin
					p_start_nxt = 1'b1;
					p_cnt_nxt = llic_pkg::ONE;
					p_red_nxt = 1'b1;
					p_beep_nxt = llic_pkg::ONE;
				end
				llic_pkg::LLIC_IDLE: begin
					if (card_read_in) begin
						p_start_nxt = 1'b1;
						p_beep_nxt = llic_pkg::ONE;
					end else if (reader_lost_in) begin
						p_start_nxt = 1'b1;
						p_cnt_nxt = llic_pkg::ONE;
						p_red_nxt = 1'b1;
					end
				end
				default: begin
					p_start_nxt = 1'b0;
				end
			endcase
		end
	end

	llic_pulser #(
		.ON_CYC(ON_CYC),
		.OFF_CYC(OFF_CYC),
		.LONG_CYC(LONG_CYC)
	) u_pulser (
		.clk_in(core_clk_in),
		.rst_n_in(rst_r),
		.ce_in(ce_in),
		.start_in(p_start_nxt),
		.count_in(p_cnt_nxt),
		.red_in(p_red_nxt),
		.green_in(p_green_nxt),
		.beeps_in(p_beep_nxt),
		.long_in(p_long_nxt),
		.busy_out(p_busy),
		.red_out(p_red),
		.green_out(p_green),
		.beep_out(p_beep)
	);

	// main sequencer; the pulser must be idle before a state with a train moves on
	always_ff @(posedge core_clk_in or negedge rst_r) begin
		if (!rst_r) begin
			state_r <= llic_pkg::LLIC_VER_MAJ;
			tmr_r <= 32'h0;
			tries_r <= 2'h0;
			chan_r <= llic_pkg::CHAN_FIRST;
			linked_out <= 1'b0;
			rf_req_out <= 1'b0;
			motor_unlock_out <= 1'b0;
			motor_lock_out <= 1'b0;
		end else if (ce_in) begin
			rf_req_out <= 1'b0;
			motor_unlock_out <= 1'b0;
			motor_lock_out <= 1'b0;
			case (state_r)
				llic_pkg::LLIC_VER_MAJ: begin
					if (p_start_nxt || VER_MAJOR == 4'h0) begin
						state_r <= llic_pkg::LLIC_VER_MIN;
					end
				end
				llic_pkg::LLIC_VER_MIN: begin
					if (p_start_nxt || VER_MINOR == 4'h0) begin
						state_r <= llic_pkg::LLIC_DONE;
					end
				end
				llic_pkg::LLIC_IDLE: begin
					tmr_r <= 32'h0;
					if (rex_r && card_edge) begin
						state_r <= llic_pkg::LLIC_ARM;
					end else if (access_grant_in) begin
						state_r <= llic_pkg::LLIC_UNLOCK;
					end else if (access_deny_in) begin
						state_r <= llic_pkg::LLIC_DENY_WAIT;
					end
				end
				llic_pkg::LLIC_ARM: begin
					if (!rex_r) begin
						state_r <= llic_pkg::LLIC_IDLE;
					end else if (tmr_r >= HOLD_CYC - 1) begin
						tmr_r <= 32'h0;
						tries_r <= 2'h0;
						state_r <= llic_pkg::LLIC_LINK_GO;
					end else begin
						tmr_r <= tmr_r + 32'h1;
					end
				end
				llic_pkg::LLIC_LINK_GO: begin
					if (p_start_nxt) begin
						state_r <= llic_pkg::LLIC_REQ;
					end
				end
				llic_pkg::LLIC_REQ: begin
					if (p_start_nxt) begin
						rf_req_out <= 1'b1;
						tries_r <= tries_r + 2'h1;
						tmr_r <= 32'h0;
						state_r <= llic_pkg::LLIC_WAIT;
					end
				end
				llic_pkg::LLIC_WAIT: begin
					if (rf_reply_in) begin
						tmr_r <= 32'h0;
						state_r <= llic_pkg::LLIC_PER;
					end else if (tmr_r >= REPLY_CYC - 1) begin
						tmr_r <= 32'h0;
						state_r <= llic_pkg::LLIC_REQ;
						if (tries_r == llic_pkg::REQ_TRIES) begin
							tries_r <= 2'h0;
							chan_r <= (chan_r == llic_pkg::CHAN_LAST) ? llic_pkg::CHAN_FIRST
								: chan_r + 4'h1;
						end
					end else begin
						tmr_r <= tmr_r + 32'h1;
					end
				end
				llic_pkg::LLIC_PER: begin
					if (tmr_r >= PER_CYC - 1) begin
						state_r <= llic_pkg::LLIC_PER_END;
					end else begin
						tmr_r <= tmr_r + 32'h1;
					end
				end
				llic_pkg::LLIC_PER_END: begin
					if (!p_busy) begin
						state_r <= rf_quality_ok_in ? llic_pkg::LLIC_OK : llic_pkg::LLIC_FAIL;
					end
				end
				llic_pkg::LLIC_OK: begin
					if (p_start_nxt) begin
						linked_out <= 1'b1;
						state_r <= llic_pkg::LLIC_DONE;
					end
				end
				llic_pkg::LLIC_FAIL: begin
					if (p_start_nxt) begin
						state_r <= llic_pkg::LLIC_DONE;
					end
				end
				llic_pkg::LLIC_DENY_WAIT: begin
					if (tmr_r >= DENY_CYC - 1) begin
						state_r <= llic_pkg::LLIC_DENY;
					end else begin
						tmr_r <= tmr_r + 32'h1;
					end
				end
				llic_pkg::LLIC_DENY: begin
					if (p_start_nxt) begin
						state_r <= llic_pkg::LLIC_DONE;
					end
				end
				llic_pkg::LLIC_UNLOCK: begin
					if (p_start_nxt) begin
						motor_unlock_out <= 1'b1;
						tmr_r <= 32'h0;
						state_r <= llic_pkg::LLIC_OPEN;
					end
				end
				llic_pkg::LLIC_OPEN: begin
					if (tmr_r >= RELOCK_CYC - 1) begin
						state_r <= llic_pkg::LLIC_RELOCK;
					end else begin
						tmr_r <= tmr_r + 32'h1;
					end
				end
				llic_pkg::LLIC_RELOCK: begin
					if (p_start_nxt) begin
						motor_lock_out <= 1'b1;
						state_r <= llic_pkg::LLIC_DONE;
					end
				end
				llic_pkg::LLIC_DONE: begin
					if (!p_busy) begin
						state_r <= llic_pkg::LLIC_IDLE;
					end
				end
				default: begin
					state_r <= llic_pkg::LLIC_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_r) begin
		if (!rst_r) begin
			rx_red_r <= 1'b0;
			rx_green_r <= 1'b0;
		end else if (ce_in) begin
			rx_green_r <= in_link && rf_good_in;
			rx_red_r <= in_link && rf_bad_in && !rf_good_in;
		end
	end

	// outputs registered so glitches from the state decode never reach the LEDs
	always_ff @(posedge core_clk_in or negedge rst_r) begin
		if (!rst_r) begin
			led_red_out <= 1'b0;
			led_green_out <= 1'b0;
			sounder_out <= 1'b0;
			rf_chan_out <= llic_pkg::CHAN_FIRST;
		end else if (ce_in) begin
			led_red_out <= p_red || rx_red_r;
			led_green_out <= p_green || rx_green_r;
			sounder_out <= p_beep;
			rf_chan_out <= chan_r;
		end
	end
endmodule

// ==== verification/llic_checker_assertions.sv ====
/*
 Port-level timing checks for the lock link and indicator controller.
 Assumes the bench's short flash timing and a bind onto llic_top.
*/
`timescale 1ns/1ps
module llic_checker (
	// clocking
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	// observed outputs
	input wire logic rf_req_out,
	input wire logic [3:0] rf_chan_out,
	input wire logic linked_out,
	input wire logic motor_unlock_out,
	input wire logic motor_lock_out,
	input wire logic led_red_out,
	input wire logic led_green_out,
	input wire logic sounder_out
);
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	logic [3:0] chan_q_r;
	logic [2:0] tries_r;
	// requests seen on the current channel
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			chan_q_r <= 4'h1;
			tries_r <= 3'h0;
		end else begin
			chan_q_r <= rf_chan_out;
			if (rf_chan_out != chan_q_r)
				tries_r <= {2'h0, rf_req_out};
			else if (rf_req_out)
				tries_r <= tries_r + 3'h1;
		end
	end
	sequence red_soon; ##[0:10] led_red_out; endsequence
	sequence green_soon; ##[0:6] led_green_out; endsequence
	sequence relock_ind; ##[0:6] (led_red_out && sounder_out); endsequence
	chan_range_a: assert property (rf_chan_out != 4'h0)
		else $error("channel out of range");
	chan_step_a: assert property ($changed(rf_chan_out) |->
		rf_chan_out == $past(rf_chan_out) + 4'h1 || rf_chan_out == 4'h1)
		else $error("channel did not step by one");
	chan_move_a: assert property (rf_chan_out != chan_q_r |-> tries_r == 3'h3)
		else $error("channel moved before three requests");
	tries_max_a: assert property (tries_r <= 3'h3)
		else $error("more than three requests on a channel");
	req_pulse_a: assert property (rf_req_out |=> !rf_req_out)
		else $error("request longer than one cycle");
	req_red_a: assert property (rf_req_out |-> red_soon)
		else $error("request without red flash");
	unlock_green_a: assert property ($rose(motor_unlock_out) |-> green_soon)
		else $error("unlock without green flash");
	relock_ind_a: assert property ($rose(motor_lock_out) |-> relock_ind)
		else $error("relock without red flash and beep");
	motor_gap_a: assert property (motor_unlock_out |=>
		(!motor_unlock_out && !motor_lock_out) [*8])
		else $error("relock too soon after unlock");
	linked_hold_a: assert property (linked_out |=> linked_out)
		else $error("linked flag dropped");
endmodule
bind llic_top llic_checker llic_checker_i (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
	.rf_req_out(rf_req_out), .rf_chan_out(rf_chan_out), .linked_out(linked_out),
	.motor_unlock_out(motor_unlock_out), .motor_lock_out(motor_lock_out),
	.led_red_out(led_red_out), .led_green_out(led_green_out), .sounder_out(sounder_out));

// ==== verification/llic_panel_model.sv ====
/*
 Panel unit model on the far side of the rf link: answers one lock's request
 and sends error-test results. Assumes the lock's clock and reset.
*/
`timescale 1ns/1ps
module llic_panel_model (
	// clocking
	input wire logic clk_in,
	input wire logic rst_n_in,
	// panel controls
	input wire logic link_mode_in,
	input wire logic [3:0] chan_sel_in,
	input wire logic poor_in,
	// rf side
	input wire logic rf_req_in,
	input wire logic [3:0] rf_chan_in,
	output logic rf_reply_out,
	output logic rf_good_out,
	output logic rf_bad_out,
	output logic rf_quality_ok_out,
	// indicator, high = solid green
	output logic ap_solid_out
);
	logic mode_q, busy;
	logic [3:0] chan_q;
	logic [7:0] age;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mode_q <= 1'b0;
			busy <= 1'b0;
			chan_q <= 4'h1;
			age <= 8'h0;
		end else begin
			mode_q <= link_mode_in;
			if (link_mode_in && !mode_q)
				chan_q <= chan_sel_in;
			if (!link_mode_in)
				busy <= 1'b0;
			else if (!busy && rf_req_in && rf_chan_in == chan_q)
				busy <= 1'b1;
			age <= !busy ? 8'h0 : (age == 8'hff ? age : age + 8'h1);
		end
	end
	// answer, then one result every 16 cycles
	assign rf_reply_out = busy && age == 8'h3;
	assign rf_good_out = busy && age > 8'h8 && age[3:0] == 4'h8 && !poor_in;
	assign rf_bad_out = busy && age > 8'h8 && age[3:0] == 4'h8 && poor_in;
	assign rf_quality_ok_out = !poor_in;
	// solid green once the test has run clean
	assign ap_solid_out = busy && age == 8'hff && !poor_in;
endmodule

// ==== verification/llic_top_tb.sv ====
/*
 Self-checking bench for llic_top, with the panel model on the rf side.
 Assumes shortened timing parameters; counts indicator rises per event.
*/
`timescale 1ns/1ps
module llic_top_tb;
	typedef struct {int ev; int r; int g; int b; int m;} llic_row_t;
	logic clk = 0, rst_n = 0, rex = 0, card = 0, rd = 0, lost = 0, grant = 0, deny = 0;
	logic link_mode = 0, poor = 0, ce = 1, ap;
	localparam int unsigned T_HOLD = 20, T_PER = 200, T_RELOCK = 50, T_REPLY = 30, T_DENY = 40;
	localparam int unsigned T_ON = 4, T_OFF = 4, T_LONG = 10;
	localparam logic [3:0] T_MAJ = 4'h2, T_MIN = 4'h1;
	logic [3:0] sel = 4'h3;
	logic rf_reply, rf_good, rf_bad, rf_ok, rf_req, linked, unl, lck, red, grn, snd;
	logic [3:0] chan;
	logic [4:0] prev_q;
	int failures = 0, comparisons = 0;
	int cnt [5] = '{0, 0, 0, 0, 0};
	int base [5];
	wire logic [4:0] outs = {lck, unl, snd, grn, red};
	llic_row_t rows [5] = '{'{0, 0, 0, 1, 0}, '{4, 0, 0, 0, 0}, '{1, 1, 0, 0, 0},
		'{2, 2, 0, 1, 0}, '{3, 1, 1, 1, 1}};
	initial begin
		forever #20 clk = ~clk;
	end
	llic_top #(.HOLD_CYC(T_HOLD), .PER_CYC(T_PER), .RELOCK_CYC(T_RELOCK), .REPLY_CYC(T_REPLY),
		.DENY_CYC(T_DENY), .ON_CYC(T_ON), .OFF_CYC(T_OFF), .LONG_CYC(T_LONG),
		.VER_MAJOR(T_MAJ), .VER_MINOR(T_MIN)) llic_top_i (
		.core_clk_in(clk), .rst_n_in(rst_n), .ce_in(ce), .rex_in(rex), .card_present_in(card),
		.card_read_in(rd), .reader_lost_in(lost), .access_grant_in(grant),
		.access_deny_in(deny), .rf_reply_in(rf_reply), .rf_good_in(rf_good), .rf_bad_in(rf_bad),
		.rf_quality_ok_in(rf_ok), .rf_req_out(rf_req), .rf_chan_out(chan), .linked_out(linked),
		.motor_unlock_out(unl), .motor_lock_out(lck), .led_red_out(red), .led_green_out(grn),
		.sounder_out(snd));
	llic_panel_model llic_panel_model_i (.clk_in(clk), .rst_n_in(rst_n),
		.link_mode_in(link_mode), .chan_sel_in(sel), .poor_in(poor), .rf_req_in(rf_req),
		.rf_chan_in(chan), .rf_reply_out(rf_reply), .rf_good_out(rf_good), .rf_bad_out(rf_bad),
		.rf_quality_ok_out(rf_ok), .ap_solid_out(ap));
	// rises of red, green, sounder, unlock, lock
	always @(posedge clk) begin
		prev_q <= outs;
		for (int i = 0; i < 5; i++)
			if (outs[i] && !prev_q[i])
				cnt[i] = cnt[i] + 1;
	end
	task automatic print_verdict();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic mark();
		base = cnt;
	endtask
	task automatic expect_counts(input int e [5]);
		for (int i = 0; i < 5; i++)
			chk(32'(cnt[i] - base[i]), 32'(e[i]));
	endtask
	// waits until 80 silent cycles; a hang ends the run
	task automatic settle();
		int quiet;
		quiet = 0;
		for (int n = 0; n < 8000 && quiet < 80; n++) begin
			@(posedge clk);
			quiet = (outs == 5'h0) ? quiet + 1 : 0;
		end
		if (quiet < 80) begin
			failures++;
			print_verdict();
		end
	endtask
	task automatic pulse(input int ev);
		@(posedge clk);
		#1;
		case (ev)
			0: rd = 1'b1;
			1: lost = 1'b1;
			2: deny = 1'b1;
			3: grant = 1'b1;
			default: card = 1'b1;
		endcase
		@(posedge clk);
		#1;
		{rd, lost, deny, grant, card} = 5'h0;
	endtask
	task automatic do_reset();
		@(posedge clk);
		#1 rst_n = 1'b0;
		repeat (12) @(posedge clk);
		chk(32'({linked, red, grn, snd, unl, lck, rf_req}), 32'h0);
		chk(32'(chan), 32'h1);
		#1 rst_n = 1'b1;
		mark();
		settle();
		expect_counts('{2, 1, 0, 0, 0});
	endtask
	// card shown while the lever is held for the given cycles
	task automatic do_link(input int hold);
		mark();
		@(posedge clk);
		#1 rex = 1'b1;
		repeat (4) @(posedge clk);
		#1 card = 1'b1;
		repeat (hold) @(posedge clk);
		#1 {rex, card} = 2'h0;
		settle();
	endtask
	initial begin
		link_mode = 1'b1;
		do_reset();
		foreach (rows[i]) begin
			mark();
			pulse(rows[i].ev);
			settle();
			expect_counts('{rows[i].r, rows[i].g, rows[i].b, rows[i].m, rows[i].m});
		end
		// enable low: a grant pulse must be missed entirely
		#1 ce = 1'b0;
		mark();
		pulse(3);
		settle();
		#1 ce = 1'b1;
		expect_counts('{0, 0, 0, 0, 0});
		// lever released early: nothing happens
		do_link(5);
		expect_counts('{0, 0, 0, 0, 0});
		// panel on channel 3: three tries on 1 and 2, one on 3
		do_link(40);
		chk(32'(cnt[0] - base[0]), 32'h7);
		chk(32'(cnt[2] - base[2]), 32'h3);
		chk(32'({linked, chan}), 32'h13);
		chk(32'(ap), 32'h1);
		// poor channel 1 after a new panel session and a fresh reset
		#1 link_mode = 1'b0;
		sel = 4'h1;
		poor = 1'b1;
		@(posedge clk);
		#1 link_mode = 1'b1;
		do_reset();
		do_link(40);
		chk(32'(cnt[2] - base[2]), 32'h1);
		chk(32'({linked, chan}), 32'h01);
		chk(32'(ap), 32'h0);
		chk(32'(cnt[3] + cnt[4] - base[3] - base[4]), 32'h0);
		print_verdict();
	end
endmodule
